// File: rtl/dcfs_seq.sv
// duty-cycled field switch sequencer and open-drain output latch
`timescale 1ns/1ps
`include "dcfs_cfg.svh"
module dcfs_seq #(
   parameter int unsigned STB_CYC = `DCFS_STB_CYC,
   parameter int unsigned CNT_W = 22,
   parameter int unsigned FIELD_W = 12
)(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic polarity_select,
   input wire logic supply_ready,
   input wire logic signed [FIELD_W-1:0] field_sample,
   output logic sense_power_en,
   output logic q_out,
   output logic q_oe_n,
   output logic q_valid
);

   // -----------------------------------------------------------------------------
   // constants
   // -----------------------------------------------------------------------------
   localparam logic [CNT_W-1:0] OP_LAST = CNT_W'(`DCFS_OP_CYC - 1);
   localparam logic [CNT_W-1:0] CMP_AT = CNT_W'(`DCFS_OP_CYC - 1 - `DCFS_CMP_LEAD);
   localparam logic [CNT_W-1:0] STB_LAST = CNT_W'(STB_CYC - 1);
   localparam logic [CNT_W-1:0] STU_LAST = CNT_W'(`DCFS_STU_CYC - 1);

   // -----------------------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------------------
   logic pol_meta_q;
   logic pol_q;
   logic sup_meta_q;
   logic sup_q;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pol_meta_q <= 1'h1;
         pol_q <= 1'h1;
         sup_meta_q <= 1'h0;
         sup_q <= 1'h0;
      end
      else
      begin
         pol_meta_q <= polarity_select;
         pol_q <= pol_meta_q;
         sup_meta_q <= supply_ready;
         sup_q <= sup_meta_q;
      end
   end

   // -----------------------------------------------------------------------------
   // phase sequencer
   // -----------------------------------------------------------------------------
   dcfs_pkg::dcfs_phase_t phase_q;
   logic [CNT_W-1:0] cnt_q;
   logic op_end;
   logic stb_end;

   assign op_end = (phase_q == dcfs_pkg::DCFS_OPERATE) && (cnt_q == OP_LAST);
   assign stb_end = (phase_q == dcfs_pkg::DCFS_STANDBY) && (cnt_q == STB_LAST);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_q <= dcfs_pkg::DCFS_OPERATE;
         cnt_q <= '0;
      end
      else
      begin
         case (phase_q)
            dcfs_pkg::DCFS_OPERATE:
            begin
               if (op_end)
               begin
                  phase_q <= dcfs_pkg::DCFS_STANDBY;
                  cnt_q <= '0;
               end
               else
                  cnt_q <= cnt_q + 1'h1;
            end
            dcfs_pkg::DCFS_STANDBY:
            begin
               if (stb_end)
               begin
                  phase_q <= dcfs_pkg::DCFS_OPERATE;
                  cnt_q <= '0;
               end
               else
                  cnt_q <= cnt_q + 1'h1;
            end
            default:
            begin
               phase_q <= dcfs_pkg::DCFS_OPERATE;
               cnt_q <= '0;
            end
         endcase
      end
   end

   // sensing path powered only while operating
   assign sense_power_en = (phase_q == dcfs_pkg::DCFS_OPERATE);

   // -----------------------------------------------------------------------------
   // comparator
   // -----------------------------------------------------------------------------
   dcfs_cmp_if #(.FIELD_W(FIELD_W)) cmp_link ();

   // late in the phase so the sensing path has settled
   assign cmp_link.start = (phase_q == dcfs_pkg::DCFS_OPERATE) && (cnt_q == CMP_AT);
   assign cmp_link.field = field_sample;

   dcfs_cmp #(
      .FIELD_W(FIELD_W)
   ) u_cmp (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .cmp(cmp_link)
   );

   // -----------------------------------------------------------------------------
   // start-up tracking
   // -----------------------------------------------------------------------------
   logic in_window_q;
   logic [CNT_W-1:0] stu_cnt_q;
   logic fast_q;
   logic first_done_q;
   logic valid_q;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         in_window_q <= 1'h1;
         stu_cnt_q <= '0;
      end
      else if (in_window_q)
      begin
         if (stu_cnt_q == STU_LAST)
            in_window_q <= 1'h0;
         stu_cnt_q <= stu_cnt_q + 1'h1;
      end
   end

   // supply seen inside the window makes the first result trustworthy
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         fast_q <= 1'h0;
      else if (in_window_q && sup_q)
         fast_q <= 1'h1;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         first_done_q <= 1'h0;
         valid_q <= 1'h0;
      end
      else if (op_end)
      begin
         first_done_q <= 1'h1;
         if (fast_q || first_done_q)
            valid_q <= 1'h1;
      end
   end

   // -----------------------------------------------------------------------------
   // output latch and open-drain stage
   // -----------------------------------------------------------------------------
   logic oe_n_q;

   logic decided_q;

   // held from the done pulse, so a half-finished decision never reaches the pin
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         decided_q <= `DCFS_ACTIVE_RST;
      else if (cmp_link.done)
         decided_q <= cmp_link.active;
   end

   // select sampled only at the latch point; it is meant to be strapped
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         oe_n_q <= `DCFS_OE_N_RST;
      else if (op_end)
         oe_n_q <= (decided_q != pol_q);
   end
   // no other load: value held through standby

   assign q_out = 1'h0;
   assign q_oe_n = oe_n_q;
   assign q_valid = valid_q;

endmodule

// File: include/dcfs_cfg.svh
// timing and threshold constants of the duty-cycled field switch sequencer
`ifndef DCFS_CFG_SVH
`define DCFS_CFG_SVH

// -----------------------------------------------------------------------------
// clock
// -----------------------------------------------------------------------------
`define DCFS_CLK_PERIOD_NS 50

// -----------------------------------------------------------------------------
// phase timing
// -----------------------------------------------------------------------------
`define DCFS_OP_TIME_US 50
`define DCFS_OP_CYC ((`DCFS_OP_TIME_US * 1000) / `DCFS_CLK_PERIOD_NS)
`define DCFS_STB_TIME_MS 130
`define DCFS_STB_CYC ((`DCFS_STB_TIME_MS * 1000000) / `DCFS_CLK_PERIOD_NS)
`define DCFS_STU_TIME_US 12
`define DCFS_STU_CYC ((`DCFS_STU_TIME_US * 1000) / `DCFS_CLK_PERIOD_NS)
// comparison starts this many cycles before the operating phase ends
`define DCFS_CMP_LEAD 8

// -----------------------------------------------------------------------------
// switching points, sensor codes, magnitudes
// -----------------------------------------------------------------------------
`define DCFS_OPERATE_TH 100
`define DCFS_RELEASE_TH 80

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define DCFS_ACTIVE_RST 1'h0
`define DCFS_OE_N_RST 1'h1

`endif

// File: include/dcfs_pkg.sv
// types of the duty-cycled field switch sequencer
package dcfs_pkg;

   typedef enum logic [0:0] {
      DCFS_OPERATE,
      DCFS_STANDBY
   } dcfs_phase_t;

   typedef enum logic [2:0] {
      DCFS_IDLE,
      DCFS_Q_OPS,
      DCFS_Q_OPN,
      DCFS_Q_RPS,
      DCFS_Q_RPN,
      DCFS_DONE
   } dcfs_step_t;

endpackage

// File: include/dcfs_cmp_if.sv
// link between the sequencer and the threshold comparator
`timescale 1ns/1ps
interface dcfs_cmp_if #(
   parameter int unsigned FIELD_W = 12
);
   logic start;
   logic signed [FIELD_W-1:0] field;
   logic done;
   logic active;

   modport seq (
      output start,
      output field,
      input done,
      input active
   );

   modport cmp (
      input start,
      input field,
      output done,
      output active
   );
endinterface

// File: rtl/dcfs_cmp.sv
// sequential omnipolar threshold comparator with hysteresis
`timescale 1ns/1ps
`include "dcfs_cfg.svh"
module dcfs_cmp #(
   parameter int unsigned FIELD_W = 12,
   parameter logic [FIELD_W-1:0] OPERATE_TH = FIELD_W'(`DCFS_OPERATE_TH),
   parameter logic [FIELD_W-1:0] RELEASE_TH = FIELD_W'(`DCFS_RELEASE_TH)
)(
   input wire logic sys_clk,
   input wire logic rst_n,
   dcfs_cmp_if.cmp cmp
);

   // -----------------------------------------------------------------------------
   // state
   // -----------------------------------------------------------------------------
   dcfs_pkg::dcfs_step_t step_q;
   logic signed [FIELD_W-1:0] field_q;
   logic ops_q;
   logic opn_q;
   logic rps_q;
   logic rpn_q;
   logic active_q;
   logic done_q;

   // field at or beyond th on the chosen side; th is a magnitude
   function automatic logic beyond(input logic signed [FIELD_W-1:0] f, input logic [FIELD_W-1:0] th,
                                   input logic north);
      logic signed [FIELD_W:0] fx;
      logic signed [FIELD_W:0] tx;
      fx = {f[FIELD_W-1], f};
      tx = {1'h0, th};
      if (north)
         beyond = (fx <= -tx);
      else
         beyond = (fx >= tx);
   endfunction

   // -----------------------------------------------------------------------------
   // one switching point questioned per cycle
   // -----------------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         step_q <= dcfs_pkg::DCFS_IDLE;
         field_q <= '0;
         ops_q <= 1'h0;
         opn_q <= 1'h0;
         rps_q <= 1'h0;
         rpn_q <= 1'h0;
      end
      else
      begin
         case (step_q)
            dcfs_pkg::DCFS_IDLE:
            begin
               if (cmp.start)
               begin
                  field_q <= cmp.field;
                  step_q <= dcfs_pkg::DCFS_Q_OPS;
               end
            end
            dcfs_pkg::DCFS_Q_OPS:
            begin
               ops_q <= beyond(field_q, OPERATE_TH, 1'h0);
               step_q <= dcfs_pkg::DCFS_Q_OPN;
            end
            dcfs_pkg::DCFS_Q_OPN:
            begin
               opn_q <= beyond(field_q, OPERATE_TH, 1'h1);
               step_q <= dcfs_pkg::DCFS_Q_RPS;
            end
            dcfs_pkg::DCFS_Q_RPS:
            begin
               rps_q <= beyond(field_q, RELEASE_TH, 1'h0);
               step_q <= dcfs_pkg::DCFS_Q_RPN;
            end
            dcfs_pkg::DCFS_Q_RPN:
            begin
               rpn_q <= beyond(field_q, RELEASE_TH, 1'h1);
               step_q <= dcfs_pkg::DCFS_DONE;
            end
            dcfs_pkg::DCFS_DONE:
               step_q <= dcfs_pkg::DCFS_IDLE;
            default:
               step_q <= dcfs_pkg::DCFS_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------------------
   // decision with hysteresis
   // -----------------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         active_q <= `DCFS_ACTIVE_RST;
         done_q <= 1'h0;
      end
      else
      begin
         done_q <= (step_q == dcfs_pkg::DCFS_DONE);
         if (step_q == dcfs_pkg::DCFS_DONE)
         begin
            if (active_q)
               active_q <= rps_q | rpn_q;
            else
               active_q <= ops_q | opn_q;
         end
      end
   end

   assign cmp.done = done_q;
   assign cmp.active = active_q;

endmodule

// File: tb/dcfs_seq_chk.sv
// concurrent checks on the ports of the field switch sequencer
`timescale 1ns/1ps
module dcfs_seq_chk #(
   parameter int unsigned STB_CYC = 200,
   parameter int unsigned CNT_W = 22,
   parameter int unsigned FIELD_W = 12
)(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic polarity_select,
   input wire logic supply_ready,
   input wire logic signed [FIELD_W-1:0] field_sample,
   input wire logic sense_power_en,
   input wire logic q_out,
   input wire logic q_oe_n,
   input wire logic q_valid
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // -----------------------------------------------------------------
   // phase length counters
   // -----------------------------------------------------------------
   logic [31:0] op_cnt_q;
   logic [31:0] stb_cnt_q;
   logic spe_q;
   logic [1:0] falls_q;

   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         op_cnt_q <= 32'h0;
      else
         op_cnt_q <= sense_power_en ? op_cnt_q + 32'h1 : 32'h0;

   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         stb_cnt_q <= 32'h0;
      else
         stb_cnt_q <= sense_power_en ? 32'h0 : stb_cnt_q + 32'h1;

   // saturates at two: only the first two latches matter for validity
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         spe_q <= 1'h1;
         falls_q <= 2'h0;
      end
      else
      begin
         spe_q <= sense_power_en;
         if (spe_q && !sense_power_en && falls_q != 2'h2)
            falls_q <= falls_q + 2'h1;
      end

   // -----------------------------------------------------------------
   // properties
   // -----------------------------------------------------------------
   property p_op_len;
      $fell(sense_power_en) |-> op_cnt_q == 32'h3E8;
   endproperty
   a_op_len: assert property (p_op_len) else $error("operating phase length wrong");

   property p_stb_len;
      $rose(sense_power_en) |-> stb_cnt_q == 32'(STB_CYC);
   endproperty
   a_stb_len: assert property (p_stb_len) else $error("standby phase length wrong");

   property p_chg_at_end;
      $changed(q_oe_n) |-> $fell(sense_power_en);
   endproperty
   a_chg_at_end: assert property (p_chg_at_end) else $error("output moved outside phase end");

   property p_hold_stb;
      !sense_power_en ##1 !sense_power_en |-> $stable(q_oe_n);
   endproperty
   a_hold_stb: assert property (p_hold_stb) else $error("output moved in standby");

   property p_od_low;
      q_out == 1'h0;
   endproperty
   a_od_low: assert property (p_od_low) else $error("open drain data not low");

   property p_valid_stick;
      q_valid |=> q_valid;
   endproperty
   a_valid_stick: assert property (p_valid_stick) else $error("valid dropped");

   property p_valid_rise;
      $rose(q_valid) |-> $fell(sense_power_en);
   endproperty
   a_valid_rise: assert property (p_valid_rise) else $error("valid rose off a latch");

   property p_valid_second;
      falls_q == 2'h2 |-> q_valid;
   endproperty
   a_valid_second: assert property (p_valid_second) else $error("not valid after second phase");

   c_latch: cover property ($fell(sense_power_en));
   c_valid: cover property ($rose(q_valid));
   c_pull_low: cover property ($fell(q_oe_n));
endmodule

bind dcfs_seq dcfs_seq_chk #(.STB_CYC(STB_CYC), .CNT_W(CNT_W), .FIELD_W(FIELD_W)) dcfs_seq_chk_inst (
   .sys_clk(sys_clk), .rst_n(rst_n), .polarity_select(polarity_select), .supply_ready(supply_ready),
   .field_sample(field_sample), .sense_power_en(sense_power_en), .q_out(q_out), .q_oe_n(q_oe_n),
   .q_valid(q_valid));

// File: tb/dcfs_host.sv
// pull-up load and host input on the open-drain switch output
`timescale 1ns/1ps
module dcfs_host (
   input wire logic q_out,
   input wire logic q_oe_n,
   output logic pin
);
   // released pin goes to the pull-up level, never keeps the last value
   assign pin = q_oe_n ? 1'h1 : q_out;
endmodule

// File: tb/tb_dcfs_seq.sv
// self-checking bench of the field switch sequencer
`timescale 1ns/1ps
`define CHK(a, e) \
begin \
   comparisons++; \
   if ((a) !== (e)) \
   begin \
      error_cnt++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); \
   end \
end

module tb_dcfs_seq;
   // short standby keeps the run small
   localparam int unsigned STB = 200;
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic polarity_select = 1'h1;
   logic supply_ready = 1'h1;
   logic signed [11:0] field_sample = 12'h000;
   logic sense_power_en;
   logic q_out;
   logic q_oe_n;
   logic q_valid;
   logic pin;
   int error_cnt = 0;
   int comparisons = 0;

   always #25 sys_clk = ~sys_clk;

   dcfs_seq #(.STB_CYC(STB), .CNT_W(22), .FIELD_W(12)) dcfs_seq_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .polarity_select(polarity_select), .supply_ready(supply_ready),
      .field_sample(field_sample), .sense_power_en(sense_power_en), .q_out(q_out), .q_oe_n(q_oe_n),
      .q_valid(q_valid));
   dcfs_host dcfs_host_inst (.q_out(q_out), .q_oe_n(q_oe_n), .pin(pin));

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic conclude();
      if (error_cnt == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // select only changes under reset, as a strap would
   task automatic reset_dut(input logic pol, input logic sup);
      rst_n = 1'h0;
      polarity_select = pol;
      supply_ready = sup;
      field_sample = 12'h000;
      repeat (10) @(posedge sys_clk);
      #1;
      `CHK(sense_power_en, 1'h1)
      `CHK(q_valid, 1'h0)
      rst_n = 1'h1;
   endtask

   task automatic wait_spe(input logic v);
      int n;
      n = 0;
      while (sense_power_en !== v && n < 1100)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      `CHK(sense_power_en, v)
   endtask

   // one full period; field is disturbed in standby to show the latch holds
   task automatic period(input logic signed [11:0] fld, input logic exp);
      field_sample = fld;
      wait_spe(1'h0);
      `CHK(pin, exp)
      field_sample = (fld == 12'h000) ? 12'h7FF : 12'h000;
      wait_spe(1'h1);
      `CHK(pin, exp)
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_startup();
      reset_dut(1'h1, 1'h1);
      period(12'h000, 1'h1);
      `CHK(q_valid, 1'h1)
   endtask

   task automatic t_omni_hyst();
      period(12'h064, 1'h0);
      period(12'h050, 1'h0);
      period(12'h04F, 1'h1);
      period(12'hF9D, 1'h1);
      period(12'hF9C, 1'h0);
      period(12'hFB0, 1'h0);
      period(12'hFB1, 1'h1);
      period(12'h800, 1'h0);
      period(12'h000, 1'h1);
   endtask

   task automatic t_inverted();
      reset_dut(1'h0, 1'h1);
      period(12'h000, 1'h0);
      period(12'h064, 1'h1);
      period(12'h050, 1'h1);
      period(12'h04F, 1'h0);
      period(12'hF9C, 1'h1);
   endtask

   // supply flag held low past the startup window
   task automatic t_slow_supply();
      reset_dut(1'h1, 1'h0);
      period(12'h000, 1'h1);
      `CHK(q_valid, 1'h0)
      supply_ready = 1'h1;
      period(12'h000, 1'h1);
      `CHK(q_valid, 1'h1)
   endtask

   initial
   begin
      t_startup();
      t_omni_hyst();
      t_inverted();
      t_slow_supply();
      conclude();
   end

   // about 17 periods of 1200 cycles expected; generous margin
   initial
   begin
      #(40000 * 50);
      error_cnt++;
      conclude();
   end
endmodule
